// >>> src/pvp_regs.sv
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps

module pvp_regs #(
    parameter int PKT_LEN_W = 12,
    parameter logic [23:0] MAKER_OUI = 24'h5a_a5_01, // arbitrary value
    parameter logic [23:0] PART_CODE = 24'h00_12_34  // arbitrary value
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [2:0] power_class_pins,
    input wire logic bus_reset,
    input wire logic fair_req,
    input wire logic pri_req,
    input wire logic pkt_rx_done,
    input wire logic [PKT_LEN_W-1:0] pkt_rx_bits,
    output logic fair_req_pending,
    output logic pri_req_pending,
    output logic [1:0] selfid_sp,
    output logic [2:0] selfid_pwr,
    output logic [1:0] peer_speed_adv
);

    // the length compare must hold the ack length of 8 bits
    if (PKT_LEN_W < 4 || PKT_LEN_W > 16)
    begin : g_len_check
        $error("pvp_regs: PKT_LEN_W must be 4 to 16");
    end

    logic [2:0] page_sel;
    logic null_packet_flag;
    logic [1:0] link_speed;
    logic [2:0] pwr_class;
    logic pwr_loaded;
    logic aw_held;
    logic w_held;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic do_write;
    logic pkt_clears;
    logic wr_page_sel;
    logic wr_pwr_class;
    logic wr_arb_link;

    function automatic logic addr_ok(input logic [7:0] addr);
        addr_ok = (addr[1:0] == 2'b00) && (addr[7:6] == 2'b00);
    endfunction : addr_ok

    function automatic logic [3:0] addr_idx(input logic [7:0] addr);
        addr_idx = addr[5:2];
    endfunction : addr_idx

    function automatic logic reg_hit(input logic [7:0] addr, input logic [3:0] idx);
        reg_hit = addr_ok(addr) && (addr_idx(addr) == idx);
    endfunction : reg_hit

    function automatic logic [31:0] read_word(input logic [7:0] addr);
        logic [3:0] idx;
        logic [7:0] b;
        idx = addr_idx(addr);
        b = 8'h00;
        if (idx == pvp_pkg::PVP_IDX_PAGE_SEL)
            b = {5'h00, page_sel};
        else if (idx == pvp_pkg::PVP_IDX_PWR_CLASS)
            b = {4'h0, pwr_class == pvp_pkg::PVP_PWR_RESERVED, pwr_class};
        else if (idx == pvp_pkg::PVP_IDX_ARB_STATUS)
            b = {6'h00, pri_req_pending, fair_req_pending};
        else if (idx == pvp_pkg::PVP_IDX_SELFID)
            b = {3'h0, selfid_pwr, selfid_sp};
        else if (idx >= pvp_pkg::PVP_IDX_PAGED_LO && page_sel == pvp_pkg::PVP_PAGE_MAKER_OUI)
        begin
            if (idx == pvp_pkg::PVP_IDX_COMPLIANCE)
                b = pvp_pkg::PVP_COMPLIANCE_LEVEL;
            else if (idx == pvp_pkg::PVP_IDX_OUI_HI)
                b = MAKER_OUI[23:16];
            else if (idx == pvp_pkg::PVP_IDX_OUI_MID)
                b = MAKER_OUI[15:8];
            else if (idx == pvp_pkg::PVP_IDX_OUI_LO)
                b = MAKER_OUI[7:0];
            else if (idx == pvp_pkg::PVP_IDX_PART_HI)
                b = PART_CODE[23:16];
            else if (idx == pvp_pkg::PVP_IDX_PART_MID)
                b = PART_CODE[15:8];
            else if (idx == pvp_pkg::PVP_IDX_PART_LO)
                b = PART_CODE[7:0];
            else
                b = 8'h00;
        end
        else if (idx == pvp_pkg::PVP_IDX_ARB_LINK && page_sel == pvp_pkg::PVP_PAGE_VENDOR_DEP)
        begin
            b = 8'h00;
            b[pvp_pkg::PVP_NULL_PKT_BIT] = null_packet_flag;
            b[pvp_pkg::PVP_LINK_SPEED_LSB +: 2] = link_speed;
        end
        else
            b = 8'h00;
        read_word = {24'h000000, b};
    endfunction : read_word

    // write channel: address and data taken in either order
    assign do_write = aw_held && w_held && !s_axi_bvalid;

    assign wr_page_sel = do_write && w_strb[0] && reg_hit(aw_addr, pvp_pkg::PVP_IDX_PAGE_SEL);
    assign wr_pwr_class = do_write && w_strb[0] && reg_hit(aw_addr, pvp_pkg::PVP_IDX_PWR_CLASS);
    // the vendor-dependent controls are only writable while their page is shown
    assign wr_arb_link = do_write && w_strb[0] && reg_hit(aw_addr, pvp_pkg::PVP_IDX_ARB_LINK)
                         && page_sel == pvp_pkg::PVP_PAGE_VENDOR_DEP;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held <= 1'b0;
            aw_addr <= 8'h00;
            s_axi_awready <= 1'b0;
        end
        else if (do_write)
        begin
            aw_held <= 1'b0;
            s_axi_awready <= 1'b0;
        end
        else if (s_axi_awvalid && s_axi_awready)
        begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
        end
        else
            s_axi_awready <= !aw_held && !s_axi_bvalid;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            w_held <= 1'b0;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
            s_axi_wready <= 1'b0;
        end
        else if (do_write)
        begin
            w_held <= 1'b0;
            s_axi_wready <= 1'b0;
        end
        else if (s_axi_wvalid && s_axi_wready)
        begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
        end
        else
            s_axi_wready <= !w_held && !s_axi_bvalid;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= pvp_pkg::PVP_RESP_OKAY;
        end
        else if (do_write)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= addr_ok(aw_addr) ? pvp_pkg::PVP_RESP_OKAY : pvp_pkg::PVP_RESP_DECERR;
        end
        else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
    end

    // read channel: one cycle from address to data
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
        end
        else if (s_axi_rvalid)
        begin
            if (s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
        else
            s_axi_arready <= 1'b1;
    end

    // payload is only loaded on a take, so it stands while rvalid waits
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= pvp_pkg::PVP_RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rdata <= addr_ok(s_axi_araddr) ? read_word(s_axi_araddr) : 32'h00000000;
            s_axi_rresp <= addr_ok(s_axi_araddr) ? pvp_pkg::PVP_RESP_OKAY
                                                 : pvp_pkg::PVP_RESP_DECERR;
        end
    end

    // page selector stands in for the base selector field
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            page_sel <= pvp_pkg::PVP_PAGE_SEL_RESET;
        else if (wr_page_sel)
            page_sel <= w_data[2:0];
    end

    // bus_reset is deliberately absent here: both fields survive it
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            null_packet_flag <= pvp_pkg::PVP_NULL_PKT_RESET;
            link_speed <= pvp_pkg::PVP_LINK_SPEED_RESET;
        end
        else if (wr_arb_link)
        begin
            null_packet_flag <= w_data[pvp_pkg::PVP_NULL_PKT_BIT];
            // illegal code 11 is stored as written; keeping it legal is software's job
            link_speed <= w_data[pvp_pkg::PVP_LINK_SPEED_LSB +: 2];
        end
    end

    // pins are caught by the first clock after reset release, never under reset
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pwr_loaded <= 1'b0;
            pwr_class <= pvp_pkg::PVP_PWR_NONE;
        end
        else if (wr_pwr_class)
        begin
            pwr_loaded <= 1'b1;
            pwr_class <= w_data[2:0];
        end
        else if (!pwr_loaded)
        begin
            pwr_loaded <= 1'b1;
            pwr_class <= power_class_pins;
        end
    end

    always_comb
    begin
        if (null_packet_flag)
            pkt_clears = pkt_rx_done
                         && pkt_rx_bits > PKT_LEN_W'(pvp_pkg::PVP_ACK_BITS);
        else
            pkt_clears = pkt_rx_done
                         && pkt_rx_bits != PKT_LEN_W'(pvp_pkg::PVP_ACK_BITS);
    end

    // a new request in the clearing cycle wins over the clear
    always_ff @(posedge aclk)
    begin
        if (!aresetn || bus_reset)
            fair_req_pending <= 1'b0;
        else
            fair_req_pending <= fair_req || (fair_req_pending && !pkt_clears);
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn || bus_reset)
            pri_req_pending <= 1'b0;
        else
            pri_req_pending <= pri_req || (pri_req_pending && !pkt_clears);
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            selfid_sp <= pvp_pkg::PVP_LINK_SPEED_RESET;
        else
            selfid_sp <= link_speed;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            selfid_pwr <= pvp_pkg::PVP_PWR_NONE;
        else
            selfid_pwr <= pwr_class;
    end

    // peers are told s400 even for a slower link: the link speed only goes to sp
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            peer_speed_adv <= pvp_pkg::PVP_SPD_S400;
        else
            peer_speed_adv <= pvp_pkg::PVP_SPD_S400;
    end

endmodule : pvp_regs

// >>> src/pvp_pkg.sv
package pvp_pkg;

    // own register indexes, byte address is four times the index
    localparam logic [3:0] PVP_IDX_PAGE_SEL = 4'h0;
    localparam logic [3:0] PVP_IDX_PWR_CLASS = 4'h1;
    localparam logic [3:0] PVP_IDX_ARB_STATUS = 4'h2;
    localparam logic [3:0] PVP_IDX_SELFID = 4'h3;
    localparam logic [3:0] PVP_IDX_PAGED_LO = 4'h8;

    // paged window indexes
    localparam logic [3:0] PVP_IDX_COMPLIANCE = 4'h8;
    localparam logic [3:0] PVP_IDX_PAGE1_RSVD = 4'h9;
    localparam logic [3:0] PVP_IDX_OUI_HI = 4'ha;
    localparam logic [3:0] PVP_IDX_OUI_MID = 4'hb;
    localparam logic [3:0] PVP_IDX_OUI_LO = 4'hc;
    localparam logic [3:0] PVP_IDX_PART_HI = 4'hd;
    localparam logic [3:0] PVP_IDX_PART_MID = 4'he;
    localparam logic [3:0] PVP_IDX_PART_LO = 4'hf;
    localparam logic [3:0] PVP_IDX_ARB_LINK = 4'h8;

    localparam logic [2:0] PVP_PAGE_MAKER_OUI = 3'h1;
    localparam logic [2:0] PVP_PAGE_VENDOR_DEP = 3'h7;
    localparam logic [2:0] PVP_PAGE_SEL_RESET = 3'h0;

    localparam logic [7:0] PVP_COMPLIANCE_LEVEL = 8'h01;

    // arb_and_link_speed_ctrl field positions (bit 0 of the phy map is the msb)
    localparam int PVP_NULL_PKT_BIT = 7;
    localparam int PVP_LINK_SPEED_LSB = 0;

    localparam logic PVP_NULL_PKT_RESET = 1'b0;
    localparam logic [1:0] PVP_LINK_SPEED_RESET = 2'h2;

    // length of an ack packet, in bits
    localparam int PVP_ACK_BITS = 8;

    typedef enum logic [1:0] {
        PVP_SPD_S100 = 2'b00,
        PVP_SPD_S200 = 2'b01,
        PVP_SPD_S400 = 2'b10,
        PVP_SPD_ILLEGAL = 2'b11
    } pvp_speed_e;

    typedef enum logic [2:0] {
        PVP_PWR_NONE = 3'b000,
        PVP_PWR_SELF_15W = 3'b001,
        PVP_PWR_SELF_30W = 3'b010,
        PVP_PWR_SELF_45W = 3'b011,
        PVP_PWR_BUS_3W = 3'b100,
        PVP_PWR_RESERVED = 3'b101,
        PVP_PWR_BUS_NEED_3W = 3'b110,
        PVP_PWR_BUS_NEED_7W = 3'b111
    } pvp_pwr_class_e;

    localparam logic [1:0] PVP_RESP_OKAY = 2'b00;
    localparam logic [1:0] PVP_RESP_DECERR = 2'b11;

endpackage : pvp_pkg

// >>> testbench/pvp_regs_checker.sv
`timescale 1ns/10ps
module pvp_regs_checker #(
    parameter int PKT_LEN_W = 12
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic bus_reset,
    input wire logic fair_req,
    input wire logic pkt_rx_done,
    input wire logic [PKT_LEN_W-1:0] pkt_rx_bits,
    input wire logic fair_req_pending,
    input wire logic pri_req_pending,
    input wire logic [1:0] peer_speed_adv
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_adv; peer_speed_adv == 2'b10; endproperty
    a_adv: assert property (p_adv) else $error("peer speed not s400");
    property p_rlat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
    a_rlat: assert property (p_rlat) else $error("read answer late");
    property p_rdrop; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
    a_rdrop: assert property (p_rdrop) else $error("rvalid held");
    property p_bdrop; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
    a_bdrop: assert property (p_bdrop) else $error("bvalid held");
    property p_set; fair_req && !bus_reset |=> fair_req_pending; endproperty
    a_set: assert property (p_set) else $error("request not pending");
    property p_keep; fair_req_pending && !pkt_rx_done && !bus_reset |=> fair_req_pending;
    endproperty
    a_keep: assert property (p_keep) else $error("request lost");
    // an ack never clears, whatever the flag holds
    property p_ack; pkt_rx_done && pkt_rx_bits == 8 && !bus_reset && pri_req_pending
        |=> pri_req_pending; endproperty
    a_ack: assert property (p_ack) else $error("ack cleared request");
    property p_long; pkt_rx_done && pkt_rx_bits > 8 && !fair_req |=> !fair_req_pending;
    endproperty
    a_long: assert property (p_long) else $error("long packet kept request");
    c_wr: cover property (s_axi_bvalid && s_axi_bready);
    c_rd: cover property (s_axi_rvalid && s_axi_rready);
    c_clr: cover property ($fell(fair_req_pending));
endmodule : pvp_regs_checker

// >>> testbench/pvp_link_model.sv
`timescale 1ns/10ps
module pvp_link_model #(
    parameter int PKT_LEN_W = 12
) (
    input wire logic aclk,
    output logic fair_req = 1'b0,
    output logic pri_req = 1'b0,
    output logic bus_reset = 1'b0,
    output logic pkt_rx_done = 1'b0,
    output logic [PKT_LEN_W-1:0] pkt_rx_bits = '0
);
    // b set: bus reset pulse, else both request pulses
    task automatic req(input logic b);
        @(posedge aclk);
        {fair_req, pri_req, bus_reset} <= {!b, !b, b};
        @(posedge aclk);
        {fair_req, pri_req, bus_reset} <= 3'h0;
    endtask : req
    // length is stale outside the strobe, so scramble it
    task automatic pkt(input logic [PKT_LEN_W-1:0] len);
        @(posedge aclk);
        pkt_rx_done <= 1'b1;
        pkt_rx_bits <= len;
        @(posedge aclk);
        pkt_rx_done <= 1'b0;
        pkt_rx_bits <= ~len;
    endtask : pkt
endmodule : pvp_link_model

// >>> testbench/pvp_regs_test.sv
`timescale 1ns/10ps
module pvp_regs_test;
    localparam logic [23:0] OUI = 24'h3c7e11; // arbitrary value
    localparam logic [23:0] PART = 24'h0a0b0c; // arbitrary value
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awa = 8'h00;
    logic [7:0] ara = 8'h00;
    logic [31:0] wd = 32'h0;
    logic awv = 1'b0, wv = 1'b0, brd = 1'b0, arv = 1'b0, rrd = 1'b0;
    logic [2:0] pins = 3'h6;
    logic awr, wr_r, bv, arr, rv, fr, pr, bres, done, fp, pp;
    logic [1:0] bresp, rresp, sp, adv;
    logic [31:0] rdata;
    logic [2:0] pwr;
    logic [11:0] bits;
    int n_errors = 0;
    int comparisons = 0;
    int cyc = 0;
    always #20 aclk = ~aclk;
    pvp_link_model link_u (.aclk(aclk), .fair_req(fr), .pri_req(pr), .bus_reset(bres),
        .pkt_rx_done(done), .pkt_rx_bits(bits));
    pvp_regs #(.MAKER_OUI(OUI), .PART_CODE(PART)) dut_u (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wr_r), .s_axi_bresp(bresp),
        .s_axi_bvalid(bv), .s_axi_bready(brd), .s_axi_araddr(ara), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
        .s_axi_rready(rrd), .power_class_pins(pins), .bus_reset(bres), .fair_req(fr),
        .pri_req(pr), .pkt_rx_done(done), .pkt_rx_bits(bits), .fair_req_pending(fp),
        .pri_req_pending(pp), .selfid_sp(sp), .selfid_pwr(pwr), .peer_speed_adv(adv));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            n_errors++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        {awa, wd, awv, wv, brd} <= {a, d, 3'h7};
        do
        begin
            @(posedge aclk);
            if (awr) awv <= 1'b0;
            if (wr_r) wv <= 1'b0;
        end
        while (!bv);
        brd <= 1'b0;
        chk({30'h0, bresp}, 32'h0);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge aclk);
        {ara, arv, rrd} <= {a, 2'h3};
        do
        begin
            @(posedge aclk);
            if (arr) arv <= 1'b0;
        end
        while (!rv);
        rrd <= 1'b0;
        chk(rdata, exp);
        chk({30'h0, rresp}, (a < 8'h40) ? 32'h0 : {30'h0, pvp_pkg::PVP_RESP_DECERR});
    endtask : rd
    task automatic settle();
        @(posedge aclk);
        @(negedge aclk);
    endtask : settle
    task automatic t_ids();
        logic [7:0] id [8];
        id = '{8'h01, 8'h00, OUI[23:16], OUI[15:8], OUI[7:0], PART[23:16], PART[15:8], PART[7:0]};
        wr(8'h00, 32'h1);
        wr(8'h20, 32'hff);
        for (int i = 0; i < 8; i++)
            rd(8'h20 + 8'(4 * i), {24'h0, id[i]});
        rd(8'h40, 32'h0);
    endtask : t_ids
    task automatic t_speed();
        wr(8'h00, 32'h7);
        rd(8'h20, 32'h02);
        for (int s = 0; s < 3; s++)
        begin
            wr(8'h20, 32'(s));
            settle();
            chk({30'h0, sp}, 32'(s));
            chk({30'h0, adv}, 32'h2);
            rd(8'h0c, 32'h1c | 32'(s));
        end
        wr(8'h2c, 32'hff);
        rd(8'h2c, 32'h0);
    endtask : t_speed
    task automatic t_null();
        int lens [4] = '{8, 0, 5, 9};
        for (int f = 0; f < 2; f++)
        begin
            wr(8'h20, {24'h0, f[0], 7'h1});
            for (int i = 0; i < 4; i++)
            begin
                link_u.req(1'b0);
                link_u.pkt(12'(lens[i]));
                settle();
                chk({fp, pp}, (lens[i] > 8 || (f == 0 && lens[i] != 8)) ? 0 : 3);
            end
        end
        link_u.req(1'b0);
        link_u.req(1'b1);
        settle();
        chk({30'h0, fp, pp}, 32'h0);
        rd(8'h20, 32'h81);
    endtask : t_null
    task automatic t_pwr();
        for (int c = 0; c < 8; c++)
        begin
            wr(8'h04, 32'(c));
            settle();
            chk({29'h0, pwr}, 32'(c));
            rd(8'h04, {28'h0, c == 5, 3'(c)});
        end
    endtask : t_pwr
    task automatic hw_rst();
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        settle();
        settle();
    endtask : hw_rst
    always @(posedge aclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_errors++;
            conclude();
        end
    end
    initial
    begin
        hw_rst();
        chk({29'h0, pwr}, 32'h6);
        t_pwr();
        t_ids();
        t_speed();
        t_null();
        pins <= 3'h3;
        hw_rst();
        chk({29'h0, pwr}, 32'h3);
        wr(8'h00, 32'h7);
        rd(8'h20, 32'h02);
        conclude();
    end
    task automatic conclude();
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : conclude
endmodule : pvp_regs_test
bind pvp_regs pvp_regs_checker #(.PKT_LEN_W(PKT_LEN_W)) chk_u (.*);
